/* common/fbd_map.svh */
// Register offsets, field positions, reset values and codes of the diagnostic decoder.
// Included by the decoder files; definitions only.
`ifndef FBD_MAP_SVH
`define FBD_MAP_SVH

// Register byte offsets
`define FBD_CTRL_OFS 8'h00
`define FBD_STAT_OFS 8'h04
`define FBD_CHAN_OFS 8'h08
`define FBD_RESP_OFS 8'h0c
`define FBD_RESP2_OFS 8'h10
`define FBD_CNT_OFS 8'h14
`define FBD_MAP_OFS 8'h20
`define FBD_MAP_MASK 8'he0

// Control and status bits
`define FBD_CTRL_EN 0
`define FBD_CTRL_RST 1'h1
`define FBD_ST_MOD 0
`define FBD_ST_CHAN 1
`define FBD_ST_RESP 2
`define FBD_ST_HERR 3

// Header byte layout and block codes
`define FBD_TYPE_VEND 2'h0
`define FBD_TYPE_MOD 2'h1
`define FBD_TYPE_CHAN 2'h2
`define FBD_MOD_LEN_MIN 6'h02
`define FBD_MOD_LEN_MAX 6'h20
`define FBD_MOD_MAX 244
`define FBD_CHAN_HDR 8'h83

// Channel fields
`define FBD_ETY_STD_MAX 5'h09
`define FBD_ETY_SLV_MIN 5'h10
`define FBD_WID_RSVD 3'h7
`define FBD_DIR_RSVD 2'h0

// Error response codes
`define FBD_RESP_LAST 2'h3
`define FBD_SVC_XPORT 8'hd1
`define FBD_SVC_INIT 8'hd7
`define FBD_SVC_READ 8'hde
`define FBD_SVC_WRITE 8'hdf
`define FBD_ORG_DPV1 8'h80
`define FBD_ORG_FMS 8'hfe
`define FBD_ORG_HART 8'hff
`define FBD_CLS_APP 4'ha
`define FBD_CLS_ACC 4'hb
`define FBD_CLS_RES 4'hc
`define FBD_ACC_MAX 4'h9
`define FBD_RES_MAX 4'h3

`endif

/* common/fbd_pkg.sv */
// Types shared by the diagnostic decoder files.
// Assumes nothing beyond a SystemVerilog compiler.
package fbd_pkg;
  typedef enum logic [2:0] {FBD_S_HDR, FBD_S_MOD, FBD_S_CH1, FBD_S_CH2, FBD_S_SKIP} fbd_state_e;
  typedef enum logic [2:0] {FBD_SVC_SLAVE, FBD_SVC_XPORT, FBD_SVC_INIT, FBD_SVC_READ, FBD_SVC_WRITE} fbd_svc_e;
  typedef enum logic [1:0] {FBD_ORG_SLAVE, FBD_ORG_DPV1, FBD_ORG_FMS, FBD_ORG_HART} fbd_org_e;
  typedef enum logic [1:0] {FBD_CLS_OTHER, FBD_CLS_APP, FBD_CLS_ACC, FBD_CLS_RES} fbd_cls_e;
  typedef enum logic [1:0] {FBD_ETY_RSVD, FBD_ETY_STD, FBD_ETY_SLAVE} fbd_ety_e;
endpackage

/* rtl/fbd_resp_decode.sv */
// Classifies the first three bytes of a failed acyclic access reply.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
`include "fbd_map.svh"

module fbd_resp_decode (
  // Reply bytes
  input wire logic [7:0] svc_i,
  input wire logic [7:0] org_i,
  input wire logic [7:0] ec_i,
  // Classification
  output fbd_pkg::fbd_svc_e svc_kind_o,
  output fbd_pkg::fbd_org_e org_kind_o,
  output fbd_pkg::fbd_cls_e cls_kind_o,
  output logic code_known_o
);
  logic [3:0] cls;
  logic [3:0] code;
  assign cls = ec_i[7:4];
  assign code = ec_i[3:0];

  always_comb begin
    case (svc_i) // [RULE10]
      `FBD_SVC_XPORT: svc_kind_o = fbd_pkg::FBD_SVC_XPORT;
      `FBD_SVC_INIT: svc_kind_o = fbd_pkg::FBD_SVC_INIT;
      `FBD_SVC_READ: svc_kind_o = fbd_pkg::FBD_SVC_READ;
      `FBD_SVC_WRITE: svc_kind_o = fbd_pkg::FBD_SVC_WRITE;
      default: svc_kind_o = fbd_pkg::FBD_SVC_SLAVE;
    endcase
  end

  always_comb begin
    case (org_i) // [RULE11]
      `FBD_ORG_DPV1: org_kind_o = fbd_pkg::FBD_ORG_DPV1;
      `FBD_ORG_FMS: org_kind_o = fbd_pkg::FBD_ORG_FMS;
      `FBD_ORG_HART: org_kind_o = fbd_pkg::FBD_ORG_HART;
      default: org_kind_o = fbd_pkg::FBD_ORG_SLAVE;
    endcase
  end

  always_comb begin
    cls_kind_o = fbd_pkg::FBD_CLS_OTHER;
    code_known_o = 1'b0;
    case (cls)
      `FBD_CLS_APP: begin // [RULE12]
        cls_kind_o = fbd_pkg::FBD_CLS_APP;
        code_known_o = (code <= 4'h2) || (code == 4'h8) || (code == 4'h9);
      end
      `FBD_CLS_ACC: begin // [RULE13]
        cls_kind_o = fbd_pkg::FBD_CLS_ACC;
        code_known_o = (code <= `FBD_ACC_MAX);
      end
      `FBD_CLS_RES: begin // [RULE14]
        cls_kind_o = fbd_pkg::FBD_CLS_RES;
        code_known_o = (code <= `FBD_RES_MAX);
      end
      default: cls_kind_o = fbd_pkg::FBD_CLS_OTHER;
    endcase
  end
endmodule
`default_nettype wire

/* rtl/fbd_diag_decoder.sv */
// Decoder for extended diagnostic blocks and acyclic error replies, with a Wishbone register slave.
// Assumes byte streams on clk_i from the receive logic and a classic Wishbone master.
// What this block does
// RULE1: A module block has type 1 in header bits 7:6 and a length of 2 to 32 that counts the header.
// RULE2: Each bit after a module header flags one module, bit 0 of byte 1 being module 1.
// RULE3: Only 244 module flags exist, the last being bit 3 of byte 31; higher bits are dropped.
// RULE4: A channel block is three bytes whose header is exactly 0x83.
// RULE5: Channel byte 1 holds the channel number in bits 5:0 and the direction in bits 7:6.
// RULE6: Channel byte 2 bits 4:0 hold the error type, 1 to 9 being the standard faults.
// RULE7: Error types 0 and 10 to 15 are reserved and 16 to 31 are passed on as slave codes.
// RULE8: Channel byte 2 bits 7:5 hold the channel width, 7 being reserved.
// RULE9: The slave answers a failed acyclic access with exactly four error bytes.
// RULE10: Reply byte 0 names the service: 0xD1 transport, 0xD7 initiate, 0xDE read, 0xDF write.
// RULE11: Reply byte 1 names the origin 0x80, 0xFE or 0xFF, other values passed on unchanged.
// RULE12: Reply byte 2 is class in bits 7:4 and code in bits 3:0, class 0xA being application errors.
// RULE13: Class 0xB is an access error with codes 0 to 9.
// RULE14: Class 0xC is a resource error with codes 0 to 3.
// RULE15: Every block starts with a header of length in bits 5:0 and type in bits 7:6.
// RULE16: The header length steps the decoder to the next block.
// RULE17: A header whose length or type fits no known layout raises the error flag.
`timescale 1ns/1ps
`default_nettype none
`include "fbd_map.svh"

module fbd_diag_decoder #(
  parameter int MOD_COUNT = `FBD_MOD_MAX
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Extended diagnostic byte stream
  input wire logic dg_valid_i,
  input wire logic dg_start_i,
  input wire logic [7:0] dg_data_i,
  // Error reply byte stream
  input wire logic er_valid_i,
  input wire logic er_start_i,
  input wire logic [7:0] er_data_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Status
  output logic blk_err_o
);
  if (MOD_COUNT < 1 || MOD_COUNT > 248) begin : g_bad_count
    $error("MOD_COUNT must lie in 1..248");
  end

  localparam logic [255:0] MOD_LIM = (256'h1 << MOD_COUNT) - 256'h1;

  fbd_pkg::fbd_state_e st_q, st_d;
  logic [5:0] rem_q, rem_d;
  logic [4:0] idx_q, idx_d;
  logic en_q;
  logic [3:0] stat_q;
  logic [19:0] chan_q;
  logic [7:0] ch1_q;
  logic [31:0] resp_q;
  logic [15:0] resp2_q;
  logic [7:0] rb_q [0:2];
  logic [1:0] ridx_q;
  logic [15:0] blk_cnt_q;
  logic [15:0] err_cnt_q;
  logic [7:0] mod_q [1:31];
  logic [255:0] mod_flat;
  logic ack_q;
  logic [31:0] rdat_q;

  logic take, at_hdr;
  logic [1:0] h_type;
  logic [5:0] h_len;
  logic hdr_bad, blk_ok, mod_start, mod_wr, mod_done, ch1_wr, ch_done;
  logic resp_done;
  logic wb_req, wr_stat, wr_ctrl;
  fbd_pkg::fbd_svc_e svc_kind;
  fbd_pkg::fbd_org_e org_kind;
  fbd_pkg::fbd_cls_e cls_kind;
  logic code_known;
  fbd_pkg::fbd_ety_e ety_kind;

  assign take = dg_valid_i & en_q;
  assign at_hdr = take & (dg_start_i | (st_q == fbd_pkg::FBD_S_HDR));
  assign h_type = dg_data_i[7:6]; // [RULE15]
  assign h_len = dg_data_i[5:0];

  // Block walker
  always_comb begin
    st_d = st_q;
    rem_d = rem_q;
    idx_d = idx_q;
    hdr_bad = 1'b0;
    blk_ok = 1'b0;
    mod_start = 1'b0;
    mod_wr = 1'b0;
    mod_done = 1'b0;
    ch1_wr = 1'b0;
    ch_done = 1'b0;
    if (at_hdr) begin
      st_d = fbd_pkg::FBD_S_HDR;
      rem_d = h_len - 6'h01;
      if (h_type == `FBD_TYPE_MOD && h_len >= `FBD_MOD_LEN_MIN && h_len <= `FBD_MOD_LEN_MAX) begin // [RULE1]
        st_d = fbd_pkg::FBD_S_MOD;
        idx_d = 5'h01;
        mod_start = 1'b1;
        blk_ok = 1'b1;
      end else if (dg_data_i == `FBD_CHAN_HDR) begin // [RULE4]
        st_d = fbd_pkg::FBD_S_CH1;
        blk_ok = 1'b1;
      end else if (h_type == `FBD_TYPE_VEND && h_len != 6'h00) begin
        blk_ok = 1'b1;
        if (h_len > 6'h01) begin // [RULE16]
          st_d = fbd_pkg::FBD_S_SKIP;
        end
      end else begin
        hdr_bad = 1'b1; // [RULE17]
        if (h_len > 6'h01) begin
          st_d = fbd_pkg::FBD_S_SKIP;
        end
      end
    end else if (take) begin
      case (st_q)
        fbd_pkg::FBD_S_MOD: begin
          mod_wr = 1'b1;
          idx_d = idx_q + 5'h01;
          rem_d = rem_q - 6'h01;
          if (rem_q == 6'h01) begin // [RULE16]
            st_d = fbd_pkg::FBD_S_HDR;
            mod_done = 1'b1;
          end
        end
        fbd_pkg::FBD_S_CH1: begin
          ch1_wr = 1'b1;
          st_d = fbd_pkg::FBD_S_CH2;
        end
        fbd_pkg::FBD_S_CH2: begin
          ch_done = 1'b1;
          st_d = fbd_pkg::FBD_S_HDR;
        end
        fbd_pkg::FBD_S_SKIP: begin
          rem_d = rem_q - 6'h01;
          if (rem_q == 6'h01) begin // [RULE16]
            st_d = fbd_pkg::FBD_S_HDR;
          end
        end
        default: st_d = fbd_pkg::FBD_S_HDR;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !en_q) begin
      st_q <= fbd_pkg::FBD_S_HDR;
      rem_q <= 6'h00;
      idx_q <= 5'h00;
    end else begin
      st_q <= st_d;
      rem_q <= rem_d;
      idx_q <= idx_d;
    end
  end

  // Module flag map, cleared when a new module block begins
  for (genvar g = 1; g <= 31; g++) begin : g_mod
    always_ff @(posedge clk_i) begin
      if (rst_i || mod_start) begin
        mod_q[g] <= 8'h00;
      end else if (mod_wr && idx_q == 5'(g)) begin
        mod_q[g] <= dg_data_i & MOD_LIM[(g-1)*8 +: 8]; // [RULE2] [RULE3]
      end
    end
    assign mod_flat[(g-1)*8 +: 8] = mod_q[g];
  end
  assign mod_flat[255:248] = 8'h00;

  // Channel fields
  always_comb begin
    if (dg_data_i[4:0] >= `FBD_ETY_SLV_MIN) begin
      ety_kind = fbd_pkg::FBD_ETY_SLAVE; // [RULE7]
    end else if (dg_data_i[4:0] == 5'h00 || dg_data_i[4:0] > `FBD_ETY_STD_MAX) begin
      ety_kind = fbd_pkg::FBD_ETY_RSVD; // [RULE7]
    end else begin
      ety_kind = fbd_pkg::FBD_ETY_STD; // [RULE6]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ch1_q <= 8'h00;
      chan_q <= 20'h00000;
    end else begin
      if (ch1_wr) begin
        ch1_q <= dg_data_i;
      end
      if (ch_done) begin
        chan_q <= {ch1_q[7:6] == `FBD_DIR_RSVD, dg_data_i[7:5] == `FBD_WID_RSVD, ety_kind,
                   dg_data_i, ch1_q}; // [RULE5] [RULE6] [RULE8]
      end
    end
  end

  // Error reply collector
  assign resp_done = er_valid_i && en_q && !er_start_i && ridx_q == `FBD_RESP_LAST;

  fbd_resp_decode u_resp (
    .svc_i(rb_q[0]),
    .org_i(rb_q[1]),
    .ec_i(rb_q[2]),
    .svc_kind_o(svc_kind),
    .org_kind_o(org_kind),
    .cls_kind_o(cls_kind),
    .code_known_o(code_known)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ridx_q <= 2'h0;
      rb_q[0] <= 8'h00;
      rb_q[1] <= 8'h00;
      rb_q[2] <= 8'h00;
      resp_q <= 32'h00000000;
      resp2_q <= 16'h0000;
    end else if (er_valid_i && en_q) begin
      if (er_start_i) begin
        rb_q[0] <= er_data_i;
        ridx_q <= 2'h1;
      end else if (resp_done) begin // [RULE9]
        resp_q <= {rb_q[2], rb_q[1], rb_q[0]} | 32'h00000000;
        resp2_q <= {code_known, cls_kind, org_kind, svc_kind, er_data_i}; // [RULE10] [RULE11] [RULE12]
        ridx_q <= 2'h0;
      end else begin
        rb_q[ridx_q] <= er_data_i;
        ridx_q <= ridx_q + 2'h1;
      end
    end
  end

  // Wishbone slave: one wait state, ack for one cycle
  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr_stat = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `FBD_STAT_OFS);
  assign wr_ctrl = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `FBD_CTRL_OFS);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q <= `FBD_CTRL_RST;
    end else if (wr_ctrl) begin
      en_q <= wb_dat_i[`FBD_CTRL_EN];
    end
  end

  // Sticky events: a set in the clearing cycle survives
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_q <= 4'h0;
    end else begin
      stat_q <= (stat_q & ~(wr_stat ? wb_dat_i[3:0] : 4'h0)) |
                {hdr_bad, resp_done, ch_done, mod_done}; // [RULE17]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blk_cnt_q <= 16'h0000;
      err_cnt_q <= 16'h0000;
    end else begin
      blk_cnt_q <= blk_cnt_q + {15'h0000, blk_ok};
      err_cnt_q <= err_cnt_q + {15'h0000, hdr_bad};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
      blk_err_o <= 1'b0;
    end else begin
      ack_q <= wb_req;
      blk_err_o <= stat_q[`FBD_ST_HERR];
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `FBD_CTRL_OFS: rdat_q <= {31'h00000000, en_q};
          `FBD_STAT_OFS: rdat_q <= {28'h0000000, stat_q};
          `FBD_CHAN_OFS: rdat_q <= {12'h000, chan_q};
          `FBD_RESP_OFS: rdat_q <= resp_q;
          `FBD_RESP2_OFS: rdat_q <= {16'h0000, resp2_q};
          `FBD_CNT_OFS: rdat_q <= {err_cnt_q, blk_cnt_q};
          default: begin
            if ((wb_adr_i & `FBD_MAP_MASK) == `FBD_MAP_OFS) begin
              rdat_q <= mod_flat[wb_adr_i[4:2]*32 +: 32];
            end else begin
              rdat_q <= 32'h00000000;
            end
          end
        endcase
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_mod_hdr_take: assert property (at_hdr && h_type == 2'h1 && h_len >= 6'h02 && h_len <= 6'h20
    |=> st_q == fbd_pkg::FBD_S_MOD && rem_q == $past(h_len) - 6'h01) else $error("module header not taken"); // [RULE1]
  a_mod_bad_len: assert property (at_hdr && h_type == 2'h1 && (h_len < 6'h02 || h_len > 6'h20)
    |=> stat_q[3]) else $error("bad module length not flagged"); // [RULE17]
  a_mod_bit_map: assert property (mod_wr && idx_q == 5'h01 && !mod_start
    |=> mod_q[1] == $past(dg_data_i)) else $error("module byte 1 not mapped"); // [RULE2]
  a_mod_limit: assert property (mod_q[31][7:4] == 4'h0) else $error("flag beyond module 244"); // [RULE3]
  a_chan_hdr: assert property (at_hdr && dg_data_i == 8'h83 ##1 take ##1 take
    |=> stat_q[1] && chan_q[7:0] == $past(dg_data_i, 2)) else $error("channel block not decoded"); // [RULE4]
  a_chan_width: assert property (ch_done |=> chan_q[15:13] == $past(dg_data_i[7:5])
    && chan_q[18] == ($past(dg_data_i[7:5]) == 3'h7)) else $error("channel width wrong"); // [RULE8]
  a_ety_slave: assert property (ch_done && dg_data_i[4:0] >= 5'h10
    |=> chan_q[17:16] == 2'(fbd_pkg::FBD_ETY_SLAVE)) else $error("slave error type not passed"); // [RULE7]
  a_resp_svc: assert property (resp_done && rb_q[0] == 8'hde
    |=> resp2_q[10:8] == 3'(fbd_pkg::FBD_SVC_READ) && stat_q[2]) else $error("read service wrong"); // [RULE10]
  a_skip_step: assert property (at_hdr && h_type == 2'h0 && h_len == 6'h03 ##1 take[*2]
    |=> st_q == fbd_pkg::FBD_S_HDR) else $error("length step wrong"); // [RULE16]
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");

  c_mod_block: cover property (mod_done);
  c_chan_block: cover property (ch_done);
  c_resp_done: cover property (resp_done);
  c_hdr_error: cover property (hdr_bad);
endmodule
`default_nettype wire

/* sim/fbd_slave_model.sv */
// DP slave model: sends extended diagnostic blocks and error replies.
// Assumes its tasks are called from one process synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module fbd_slave_model (
  // Clock
  input wire logic clk_i,
  // Diagnostic stream
  output logic dg_valid_o,
  output logic dg_start_o,
  output logic [7:0] dg_data_o,
  // Error reply stream
  output logic er_valid_o,
  output logic er_start_o,
  output logic [7:0] er_data_o
);
  initial begin
    dg_valid_o = 1'b0;
    dg_start_o = 1'b0;
    dg_data_o = 8'h00;
    er_valid_o = 1'b0;
    er_start_o = 1'b0;
    er_data_o = 8'h00;
  end
  // Whole extended area; idle data lines show the inverse of the last byte
  task automatic dg_send(input logic [7:0] q[$], input int gap);
    foreach (q[i]) begin
      @(posedge clk_i);
      dg_valid_o <= 1'b1;
      dg_start_o <= (i == 0);
      dg_data_o <= q[i];
      repeat (gap + (i == q.size() - 1)) begin
        @(posedge clk_i);
        dg_valid_o <= 1'b0;
        dg_start_o <= 1'b0;
        dg_data_o <= ~q[i];
      end
    end
  endtask
  // Exactly four reply bytes, byte 0 in the low bits
  task automatic er_send(input logic [31:0] w, input int gap);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      er_valid_o <= 1'b1;
      er_start_o <= (i == 0);
      er_data_o <= w[8*i+:8];
      repeat (gap + (i == 3)) begin
        @(posedge clk_i);
        er_valid_o <= 1'b0;
        er_start_o <= 1'b0;
        er_data_o <= ~w[8*i+:8];
      end
    end
  endtask
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// Self-checking bench of the diagnostic decoder.
// Assumes the slave model drives the streams and this bench the Wishbone side.
`timescale 1ns/1ps
`default_nettype none
`include "fbd_map.svh"
module tb_top;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, blk_err_o;
  logic dg_v, dg_s, er_v, er_s;
  logic [7:0] dg_d, er_d, wb_adr_i, b1, b2;
  logic [7:0] q[$];
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd, seed, t, w;
  logic [31:0] mp[8];
  int err_count, checks_done, cyc_n, m;
  fbd_slave_model fbd_slave_model_inst (.clk_i(clk_i), .dg_valid_o(dg_v), .dg_start_o(dg_s),
    .dg_data_o(dg_d), .er_valid_o(er_v), .er_start_o(er_s), .er_data_o(er_d));
  fbd_diag_decoder fbd_diag_decoder_inst (.clk_i(clk_i), .rst_i(rst_i), .dg_valid_i(dg_v),
    .dg_start_i(dg_s), .dg_data_i(dg_d), .er_valid_i(er_v), .er_start_i(er_s), .er_data_i(er_d),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .blk_err_o(blk_err_o));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] chan_exp(input logic [7:0] c1, input logic [7:0] c2);
    logic [1:0] k;
    k = (c2[4:0] >= 5'h10) ? 2'h2 : ((c2[4:0] != 5'h00 && c2[4:0] <= 5'h09) ? 2'h1 : 2'h0);
    return {12'h000, c1[7:6] == 2'h0, c2[7:5] == 3'h7, k, c2, c1};
  endfunction
  function automatic logic [31:0] resp2_exp(input logic [31:0] r);
    logic [2:0] s;
    logic [1:0] o, c;
    logic k;
    case (r[7:0])
      8'hd1: s = 3'h1;
      8'hd7: s = 3'h2;
      8'hde: s = 3'h3;
      8'hdf: s = 3'h4;
      default: s = 3'h0;
    endcase
    case (r[15:8])
      8'h80: o = 2'h1;
      8'hfe: o = 2'h2;
      8'hff: o = 2'h3;
      default: o = 2'h0;
    endcase
    c = (r[23:20] >= 4'ha && r[23:20] <= 4'hc) ? 2'(r[23:20] - 4'h9) : 2'h0;
    case (c)
      2'h1: k = r[19:16] <= 4'h2 || r[19:16] == 4'h8 || r[19:16] == 4'h9;
      2'h2: k = r[19:16] <= 4'h9;
      2'h3: k = r[19:16] <= 4'h3;
      default: k = 1'b0;
    endcase
    return {16'h0000, k, c, o, s, r[31:24]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One classic cycle; read data lands in rd
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      err_count = err_count + 1;
      finish_test();
    end
  end
  initial begin
    seed = 32'h5654be3e;
    err_count = 0;
    checks_done = 0;
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hf;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(`FBD_CTRL_OFS, 32'h1);
    wb(1'b1, 8'h18, 32'hffffffff);
    rc(8'h18, 32'h0);
    // Every error type, channel width and direction, random channel
    for (int i = 0; i < 32; i++) begin
      t = xs();
      b1 = {2'(i), t[5:0]};
      b2 = {3'(i), 5'(i)};
      q = {8'h83, b1, b2};
      fbd_slave_model_inst.dg_send(q, i % 3);
      rc(`FBD_CHAN_OFS, chan_exp(b1, b2));
      rc(`FBD_STAT_OFS, 32'h2);
      wb(1'b1, `FBD_STAT_OFS, 32'h2);
    end
    // Longest module block, bits past the last module forced high
    q = {8'h60};
    for (int k = 1; k < 32; k++) begin
      t = xs();
      q.push_back(k == 31 ? (t[7:0] | 8'hf0) : t[7:0]);
    end
    mp = '{default: 32'h0};
    for (m = 0; m < 248; m++) begin
      if (m < 244) mp[m / 32][m % 32] = q[m / 8 + 1][m % 8];
    end
    fbd_slave_model_inst.dg_send(q, 0);
    for (int k = 0; k < 8; k++) begin
      rc(8'(`FBD_MAP_OFS + 4 * k), mp[k]);
    end
    // Short module block, a vendor block to skip, then a channel block right behind it
    q = {8'h42, 8'h05, 8'h03, 8'h83, 8'h42, 8'h83, b2, b1};
    fbd_slave_model_inst.dg_send(q, 0);
    rc(`FBD_MAP_OFS, 32'h5);
    rc(8'(`FBD_MAP_OFS + 4), 32'h0);
    rc(`FBD_CHAN_OFS, chan_exp(b2, b1));
    rc(`FBD_STAT_OFS, 32'h3);
    // Type 3, short module and bad channel headers, then a good vendor block, before a good block
    t = xs();
    q = {8'hc3, t[7:0], t[15:8], 8'h41, 8'h84, t[23:16], t[31:24], t[7:0], 8'h03, t[15:8], t[7:0],
      8'h83, b1, b2};
    wb(1'b1, `FBD_STAT_OFS, 32'hf);
    fbd_slave_model_inst.dg_send(q, 1);
    rc(`FBD_CHAN_OFS, chan_exp(b1, b2));
    rc(`FBD_STAT_OFS, 32'ha);
    chk({31'h0, blk_err_o}, 32'h1);
    wb(1'b0, `FBD_CNT_OFS, 32'h0);
    chk({16'h0, rd[31:16]}, 32'h3);
    chk({16'h0, rd[15:0]}, 32'h26);
    wb(1'b1, `FBD_STAT_OFS, 32'hf);
    // Disabled decoder must ignore a whole stream, bad headers included
    wb(1'b1, `FBD_CTRL_OFS, 32'h0);
    fbd_slave_model_inst.dg_send(q, 0);
    rc(`FBD_STAT_OFS, 32'h0);
    rc(`FBD_CTRL_OFS, 32'h0);
    wb(1'b1, `FBD_CTRL_OFS, 32'h1);
    // Every service, origin and class, random codes and trailing byte
    for (int i = 0; i < 20; i++) begin
      t = xs();
      w[7:0] = (i % 5 == 4) ? t[15:8] : (i % 5 == 3 ? 8'hdf : (i % 5 == 2 ? 8'hde : (i % 5 == 1 ? 8'hd7 : 8'hd1)));
      w[15:8] = (i % 4 == 3) ? t[23:16] : 8'h80 | (i % 4 == 0 ? 8'h00 : (i % 4 == 1 ? 8'h7e : 8'h7f));
      w[23:16] = {(i % 4 == 3) ? t[7:4] : 4'(4'ha + i % 4), t[3:0]};
      w[31:24] = t[31:24];
      fbd_slave_model_inst.er_send(w, i % 2);
      rc(`FBD_RESP_OFS, {8'h00, w[23:0]});
      rc(`FBD_RESP2_OFS, resp2_exp(w));
    end
    rc(`FBD_STAT_OFS, 32'h4);
    finish_test();
  end
endmodule
`default_nettype wire
